// file: hw/pecc_regs.sv
// Design: receive error counters and coding path configuration registers
//
// Contract
// - False carrier event adds one to tally
// - False carrier tally sticks at all ones
// - False carrier tally resets zero, writable, cleared on read
// - Reserved bits ignore writes, read zero
// - Receive error tally advances on receive error
// - Count only invalid symbol during valid carrier
// - At most one count per carrier event
// - No count for carrier with collision
// - Receive error tally saturates, resets, writable, read clears
// - Bit 12 bypasses block coder
// - Bit 11 makes receive clock free running
// - Bit 10 enables silent transmit
// - Bit 9 forces signal detect
// - Bit 8 resets one, selects enhanced detect
// - Bit 5 forces good fast link
// - Bit 2 bypasses NRZI stage
// - Bit 1 bypasses transmit scrambler
// - Bit 0 bypasses receive descrambler
`timescale 1ns/1ps
`default_nettype none

module pecc_regs (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic [pecc_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [31:0]                 avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic      [31:0]                 avs_readdata_o,
  output logic                             avs_waitrequest_o,
  input  wire pecc_pkg::pecc_rx_event_type rx_event_i,
  output pecc_pkg::pecc_cfg_type           cfg_o
);

  logic [7:0]  fc_tally_r;
  logic [7:0]  re_tally_r;
  logic [15:0] cfg_r;
  logic        ack_r;
  logic        in_carrier_r;
  logic        sym_err_r;
  logic        coll_r;
  logic [31:0] rdata_nxt;
  logic        re_event;
  logic        access;
  logic        wr_go;
  logic        rd_go;
  logic        lo_en;
  logic        hi_en;

  // Saturating step with clear-on-read and write handling; write beats clear, an event adds one on top of either
  function automatic logic [7:0] tally_next(input logic [7:0] cur,
                                            input logic       ev,
                                            input logic       rd_clr,
                                            input logic       wr,
                                            input logic [7:0] wval);
    logic [7:0] base;
    base = wr ? wval : (rd_clr ? pecc_pkg::CNT_RESET : cur);
    if (ev && base != pecc_pkg::CNT_MAX) begin
      tally_next = base + 8'h01;
    end else begin
      tally_next = base;
    end
  endfunction

  // One wait cycle: request seen, answered on the next edge
  assign access = (avs_read_i || avs_write_i) && !ack_r;
  assign wr_go  = avs_write_i && ack_r;
  assign rd_go  = avs_read_i && ack_r;
  assign lo_en  = avs_byteenable_i[0];
  assign hi_en  = avs_byteenable_i[1];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !access;
    end
  end

  // Carrier tracking; inputs come from logic on this clock
  // A carrier with an invalid symbol and no collision counts once at its end, so at most one count per carrier
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_carrier_r <= 1'b0;
      sym_err_r    <= 1'b0;
      coll_r       <= 1'b0;
    end else if (rx_event_i.carrier_valid) begin
      in_carrier_r <= 1'b1;
      sym_err_r    <= sym_err_r | rx_event_i.invalid_symbol;
      coll_r       <= coll_r | rx_event_i.collision;
    end else begin
      in_carrier_r <= 1'b0;
      sym_err_r    <= 1'b0;
      coll_r       <= 1'b0;
    end
  end

  assign re_event = in_carrier_r && !rx_event_i.carrier_valid
                    && sym_err_r && !coll_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fc_tally_r <= pecc_pkg::CNT_RESET;
    end else begin
      fc_tally_r <= tally_next(fc_tally_r, rx_event_i.false_carrier,
        rd_go && avs_address_i == pecc_pkg::IDX_FC_COUNT,
        wr_go && lo_en && avs_address_i == pecc_pkg::IDX_FC_COUNT,
        avs_writedata_i[7:0]);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      re_tally_r <= pecc_pkg::CNT_RESET;
    end else begin
      re_tally_r <= tally_next(re_tally_r, re_event,
        rd_go && avs_address_i == pecc_pkg::IDX_RE_COUNT,
        wr_go && lo_en && avs_address_i == pecc_pkg::IDX_RE_COUNT,
        avs_writedata_i[7:0]);
    end
  end

  // Reserved bits never store
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r <= pecc_pkg::CFG_RESET;
    end else if (wr_go && avs_address_i == pecc_pkg::IDX_CFG) begin
      if (lo_en) begin
        cfg_r[7:0] <= avs_writedata_i[7:0] & pecc_pkg::CFG_WMASK[7:0];
      end
      if (hi_en) begin
        cfg_r[15:8] <= avs_writedata_i[15:8] & pecc_pkg::CFG_WMASK[15:8];
      end
    end
  end

  // Read value; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (avs_address_i)
      pecc_pkg::IDX_FC_COUNT: rdata_nxt[7:0]  = fc_tally_r;
      pecc_pkg::IDX_RE_COUNT: rdata_nxt[7:0]  = re_tally_r;
      pecc_pkg::IDX_CFG:      rdata_nxt[15:0] = cfg_r;
      default:                rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && access) begin
      avs_readdata_o <= rdata_nxt;
    end
  end

  // Datapath steering bits
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_o <= '0;
      cfg_o.signal_detect_algorithm_select <= 1'b1;
    end else begin
      cfg_o.block_coder_skip       <= cfg_r[pecc_pkg::POS_BLOCK_SKIP];
      cfg_o.free_running_rx_clock  <= cfg_r[pecc_pkg::POS_FREE_CLK];
      cfg_o.silent_transmit_enable <= cfg_r[pecc_pkg::POS_SILENT_TX];
      cfg_o.signal_detect_override <= cfg_r[pecc_pkg::POS_SD_OVERRIDE];
      cfg_o.signal_detect_algorithm_select
        <= cfg_r[pecc_pkg::POS_SD_ALGO];
      cfg_o.force_link_good        <= cfg_r[pecc_pkg::POS_FORCE_LINK];
      cfg_o.nrzi_skip              <= cfg_r[pecc_pkg::POS_NRZI_SKIP];
      cfg_o.scrambler_skip         <= cfg_r[pecc_pkg::POS_SCRAM_SKIP];
      cfg_o.descrambler_skip       <= cfg_r[pecc_pkg::POS_DESCRAM_SKIP];
    end
  end

  // Assertions
  property p_fc_count;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rx_event_i.false_carrier && !ack_r && fc_tally_r != 8'hff)
      |=> fc_tally_r == $past(fc_tally_r) + 8'h01;
  endproperty
  a_fc_count: assert property (p_fc_count)
    else $error("false carrier tally did not step");

  property p_fc_sat;
    @(posedge clk_i) disable iff (!rst_n_i)
    (fc_tally_r == 8'hff && !ack_r) |=> fc_tally_r == 8'hff;
  endproperty
  a_fc_sat: assert property (p_fc_sat)
    else $error("false carrier tally wrapped");

  property p_fc_cor;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_go && avs_address_i == 8'h14 && !rx_event_i.false_carrier)
      |=> fc_tally_r == 8'h00;
  endproperty
  a_fc_cor: assert property (p_fc_cor)
    else $error("false carrier tally not cleared by read");

  property p_rsvd;
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_go |-> (avs_readdata_o[31:16] == 16'h0000
               && cfg_r[15:13] == 3'b000 && cfg_r[7:6] == 2'b00
               && cfg_r[4:3] == 2'b00);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits not zero");

  property p_re_once;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rx_event_i.carrier_valid && !ack_r) |=> re_tally_r == $past(re_tally_r);
  endproperty
  a_re_once: assert property (p_re_once)
    else $error("receive error tally moved inside a carrier");

  property p_re_count;
    @(posedge clk_i) disable iff (!rst_n_i)
    (re_event && !ack_r && re_tally_r != 8'hff)
      |=> re_tally_r == $past(re_tally_r) + 8'h01;
  endproperty
  a_re_count: assert property (p_re_count)
    else $error("receive error tally did not step");

  property p_re_coll;
    @(posedge clk_i) disable iff (!rst_n_i)
    (coll_r && !rx_event_i.carrier_valid && !ack_r)
      |=> re_tally_r == $past(re_tally_r);
  endproperty
  a_re_coll: assert property (p_re_coll)
    else $error("receive error counted despite collision");

  property p_re_cor;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_go && avs_address_i == 8'h15) |=> re_tally_r <= 8'h01;
  endproperty
  a_re_cor: assert property (p_re_cor)
    else $error("receive error tally not cleared by read");

  property p_cor_keep;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_go && avs_address_i == 8'h14 && rx_event_i.false_carrier)
      |=> fc_tally_r == 8'h01;
  endproperty
  a_cor_keep: assert property (p_cor_keep)
    else $error("event lost during clearing read");

  property p_cfg_out;
    @(posedge clk_i) disable iff (!rst_n_i)
    ##1 (cfg_o.block_coder_skip == $past(cfg_r[12])
         && cfg_o.free_running_rx_clock == $past(cfg_r[11])
         && cfg_o.silent_transmit_enable == $past(cfg_r[10])
         && cfg_o.signal_detect_override == $past(cfg_r[9])
         && cfg_o.signal_detect_algorithm_select == $past(cfg_r[8])
         && cfg_o.force_link_good == $past(cfg_r[5])
         && cfg_o.nrzi_skip == $past(cfg_r[2])
         && cfg_o.scrambler_skip == $past(cfg_r[1])
         && cfg_o.descrambler_skip == $past(cfg_r[0]));
  endproperty
  a_cfg_out: assert property (p_cfg_out)
    else $error("configuration output does not follow register");

  // Holding checks: with no event and no access a tally must not move
  property p_fc_still;
    @(posedge clk_i) disable iff (!rst_n_i)
    (!rx_event_i.false_carrier && !ack_r)
      |=> fc_tally_r == $past(fc_tally_r);
  endproperty
  a_fc_still: assert property (p_fc_still)
    else $error("false carrier tally moved without an event");

  property p_re_still;
    @(posedge clk_i) disable iff (!rst_n_i)
    (!re_event && !ack_r)
      |=> re_tally_r == $past(re_tally_r);
  endproperty
  a_re_still: assert property (p_re_still)
    else $error("receive error tally moved without a counted carrier");

  property p_re_nosym;
    @(posedge clk_i) disable iff (!rst_n_i)
    (in_carrier_r && !rx_event_i.carrier_valid && !sym_err_r && !ack_r)
      |=> re_tally_r == $past(re_tally_r);
  endproperty
  a_re_nosym: assert property (p_re_nosym)
    else $error("receive error counted for a clean carrier");

  property p_re_sat;
    @(posedge clk_i) disable iff (!rst_n_i)
    (re_tally_r == 8'hff && !ack_r) |=> re_tally_r == 8'hff;
  endproperty
  a_re_sat: assert property (p_re_sat)
    else $error("receive error tally wrapped");

  // Write and read paths, checked against the bus values seen
  property p_fc_wr;
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_go && lo_en && avs_address_i == pecc_pkg::IDX_FC_COUNT
     && !rx_event_i.false_carrier)
      |=> fc_tally_r == $past(avs_writedata_i[7:0]);
  endproperty
  a_fc_wr: assert property (p_fc_wr)
    else $error("false carrier tally write not stored");

  property p_re_wr;
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_go && lo_en && avs_address_i == pecc_pkg::IDX_RE_COUNT && !re_event)
      |=> re_tally_r == $past(avs_writedata_i[7:0]);
  endproperty
  a_re_wr: assert property (p_re_wr)
    else $error("receive error tally write not stored");

  property p_cfg_wr;
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_go && lo_en && hi_en && avs_address_i == pecc_pkg::IDX_CFG)
      |=> cfg_r == ($past(avs_writedata_i[15:0]) & pecc_pkg::CFG_WMASK);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr)
    else $error("configuration write not stored as masked");

  property p_cfg_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    !(wr_go && avs_address_i == pecc_pkg::IDX_CFG)
      |=> cfg_r == $past(cfg_r);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("configuration changed without a write");

  property p_rd_fc;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_go && avs_address_i == pecc_pkg::IDX_FC_COUNT)
      |-> avs_readdata_o == {24'h00_0000, $past(fc_tally_r)};
  endproperty
  a_rd_fc: assert property (p_rd_fc)
    else $error("false carrier read data wrong");

  property p_rd_re;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_go && avs_address_i == pecc_pkg::IDX_RE_COUNT)
      |-> avs_readdata_o == {24'h00_0000, $past(re_tally_r)};
  endproperty
  a_rd_re: assert property (p_rd_re)
    else $error("receive error read data wrong");

  property p_rd_cfg;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_go && avs_address_i == pecc_pkg::IDX_CFG)
      |-> avs_readdata_o == {16'h0000, $past(cfg_r)};
  endproperty
  a_rd_cfg: assert property (p_rd_cfg)
    else $error("configuration read data wrong");

  // One wait state: clear on read relies on the completion edge alone
  property p_wait_seq;
    @(posedge clk_i) disable iff (!rst_n_i)
    access |=> (!avs_waitrequest_o ##1 avs_waitrequest_o);
  endproperty
  a_wait_seq: assert property (p_wait_seq)
    else $error("wait request sequence wrong");

endmodule

`default_nettype wire

// file: common/pecc_pkg.sv
// Package: register map, field positions and reset values of the counter block
package pecc_pkg;

  localparam int          ADDR_W        = 8;
  // Offsets are word indices; byte address is four times the index
  localparam logic [7:0]  IDX_FC_COUNT  = 8'h14;
  localparam logic [7:0]  IDX_RE_COUNT  = 8'h15;
  localparam logic [7:0]  IDX_CFG       = 8'h16;

  localparam int          CNT_W         = 8;
  localparam logic [7:0]  CNT_RESET     = 8'h00;
  localparam logic [7:0]  CNT_MAX       = 8'hff;

  localparam int          POS_BLOCK_SKIP   = 12;
  localparam int          POS_FREE_CLK     = 11;
  localparam int          POS_SILENT_TX    = 10;
  localparam int          POS_SD_OVERRIDE  = 9;
  localparam int          POS_SD_ALGO      = 8;
  localparam int          POS_FORCE_LINK   = 5;
  localparam int          POS_NRZI_SKIP    = 2;
  localparam int          POS_SCRAM_SKIP   = 1;
  localparam int          POS_DESCRAM_SKIP = 0;

  // Writable configuration bits; everything else reads zero
  localparam logic [15:0] CFG_WMASK     = 16'h1f27;
  localparam logic [15:0] CFG_RESET     = 16'h0100;

  typedef struct packed {
    logic block_coder_skip;
    logic free_running_rx_clock;
    logic silent_transmit_enable;
    logic signal_detect_override;
    logic signal_detect_algorithm_select;
    logic force_link_good;
    logic nrzi_skip;
    logic scrambler_skip;
    logic descrambler_skip;
  } pecc_cfg_type;

  typedef struct packed {
    logic false_carrier;
    logic carrier_valid;
    logic invalid_symbol;
    logic collision;
  } pecc_rx_event_type;

endpackage

// file: testbench/pecc_host_model.sv
// Host model: Avalon-MM master issuing single register accesses
`timescale 1ns/1ps
`default_nettype none
module pecc_host_model (
  input  wire logic        clk_i,
  output logic [7:0]       address_o,
  output logic             read_o,
  output logic             write_o,
  output logic [31:0]      writedata_o,
  output logic [3:0]       byteenable_o,
  input  wire logic [31:0] readdata_i,
  input  wire logic        waitrequest_i
);
  initial begin
    address_o = 8'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0000_0000;
    byteenable_o = 4'hf;
  end
  // Request held until waitrequest is sampled low; no latency assumed
  task automatic access(input logic [7:0] a, input logic w,
                        input logic [15:0] d, input logic [3:0] be,
                        output logic [15:0] q);
    @(posedge clk_i);
    address_o <= a;
    write_o <= w;
    read_o <= ~w;
    writedata_o <= {16'h0000, d};
    byteenable_o <= be;
    @(posedge clk_i);
    while (waitrequest_i !== 1'b0) @(posedge clk_i);
    q = readdata_i[15:0];
    read_o <= 1'b0;
    write_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: testbench/test_phy_rx_error_counters_pcs_config.sv
// Testbench: counters and coding path configuration registers
`timescale 1ns/1ps
`default_nettype none
module test_phy_rx_error_counters_pcs_config;
  logic                        clk = 1'b0;
  logic                        rst_n = 1'b0;
  logic [7:0]                  addr;
  logic                        rd;
  logic                        wr;
  logic [31:0]                 wdata;
  logic [31:0]                 rdata;
  logic [3:0]                  be;
  logic                        wait_req;
  pecc_pkg::pecc_rx_event_type rx_ev = '0;
  pecc_pkg::pecc_cfg_type      cfg;
  logic [15:0]                 q;
  int                          errors = 0;
  int                          n_compared = 0;
  int                          cycles = 0;

  always #12.5 clk = ~clk;

  pecc_regs u_pecc_regs (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .rx_event_i(rx_ev), .cfg_o(cfg));

  pecc_host_model u_pecc_host_model (.clk_i(clk), .address_o(addr),
    .read_o(rd), .write_o(wr), .writedata_o(wdata), .byteenable_o(be),
    .readdata_i(rdata), .waitrequest_i(wait_req));

  task automatic chk(input string name, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    u_pecc_host_model.access(a, 1'b0, 16'h0000, 4'hf, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    u_pecc_host_model.access(a, 1'b1, d, 4'hf, q);
  endtask
  task automatic wlane(input logic [7:0] a, input logic [3:0] b,
                       input logic [15:0] d);
    u_pecc_host_model.access(a, 1'b1, d, b, q);
  endtask
  task automatic fc_pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      rx_ev.false_carrier <= 1'b1;
      @(posedge clk);
      rx_ev.false_carrier <= 1'b0;
    end
  endtask
  // Carrier with n invalid symbols; the count lands after carrier end
  task automatic carrier(input int n, input logic coll);
    @(posedge clk);
    rx_ev.carrier_valid <= 1'b1;
    rx_ev.collision <= coll;
    repeat (n) begin
      @(posedge clk);
      rx_ev.invalid_symbol <= 1'b1;
      @(posedge clk);
      rx_ev.invalid_symbol <= 1'b0;
    end
    @(posedge clk);
    rx_ev.carrier_valid <= 1'b0;
    rx_ev.collision <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset;
    rchk(8'h14, 16'h0000);
    rchk(8'h15, 16'h0000);
    rchk(8'h16, 16'h0100);
    chk("cfg", 16'h0010, {7'h00, cfg});
  endtask
  task automatic t_config;
    logic [15:0] v;
    for (int i = 0; i < 16; i++) begin
      v = 16'h0001 << i;
      wreg(8'h16, v);
      v = v & 16'h1f27;
      rchk(8'h16, v);
      chk("cfg", {7'h00, v[12:8], v[5], v[2:0]}, {7'h00, cfg});
    end
    // Unmapped index: write dropped, reads zero, config untouched
    wreg(8'h17, 16'hffff);
    rchk(8'h17, 16'h0000);
    rchk(8'h16, 16'h0000);
  endtask
  // Byte lanes: each lane stores alone, a dead lane stores nothing
  task automatic t_lanes;
    wlane(8'h16, 4'h1, 16'hffff);
    rchk(8'h16, 16'h0027);
    wlane(8'h16, 4'h2, 16'hffff);
    rchk(8'h16, 16'h1f27);
    wlane(8'h16, 4'h0, 16'h0000);
    rchk(8'h16, 16'h1f27);
    chk("cfg", 16'h01ff, {7'h00, cfg});
    wlane(8'h14, 4'h2, 16'h00ff);
    rchk(8'h14, 16'h0000);
  endtask
  task automatic t_false_carrier;
    fc_pulses(3);
    rchk(8'h14, 16'h0003);
    rchk(8'h14, 16'h0000);
    fc_pulses(300);
    rchk(8'h14, 16'h00ff);
    wreg(8'h14, 16'hff5a);
    rchk(8'h14, 16'h005a);
  endtask
  task automatic t_rx_error;
    carrier(3, 1'b0);
    rchk(8'h15, 16'h0001);
    carrier(0, 1'b0);
    carrier(2, 1'b1);
    @(posedge clk);
    rx_ev.invalid_symbol <= 1'b1;
    @(posedge clk);
    rx_ev.invalid_symbol <= 1'b0;
    rchk(8'h15, 16'h0000);
    wreg(8'h15, 16'hfffe);
    repeat (3) carrier(1, 1'b0);
    rchk(8'h15, 16'h00ff);
  endtask
  // Event lands on the very edge that completes the clearing read
  task automatic t_clear_race;
    fc_pulses(4);
    fork
      rchk(8'h14, 16'h0004);
      begin
        @(negedge wait_req);
        rx_ev.false_carrier <= 1'b1;
        @(posedge clk);
        rx_ev.false_carrier <= 1'b0;
      end
    join
    rchk(8'h14, 16'h0001);
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run needs about 840 cycles; ceiling leaves ample margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_config();
    t_lanes();
    t_false_carrier();
    t_rx_error();
    t_clear_race();
    wrap_up();
  end
endmodule
`default_nettype wire
